// ===== core/guard_prescale_counter.sv
// Prescaled watchdog count driven by the low-frequency tick.
// Assumes lf_tick is a one-cycle pulse synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module guard_prescale_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lf_tick,
  input wire logic run,
  input wire logic clear,
  input wire logic [guard_pkg::PS_W-1:0] period_sel,
  output logic expire
);

  typedef struct packed {
    logic [guard_pkg::CNT_W-1:0] count;
    logic expire;
  } cnt_state_s;

  localparam cnt_state_s CNT_RESET = '0;

  cnt_state_s q_reg;
  cnt_state_s q_next;
  logic [guard_pkg::PS_W-1:0] ps_eff;
  logic [guard_pkg::CNT_W:0] terminal;

  // Codes above the longest period fall back to the longest period.
  assign ps_eff = (period_sel > guard_pkg::PS_MAX) ?
    guard_pkg::PS_MAX : period_sel;
  assign terminal = (guard_pkg::BASE_PRESCALE << ps_eff) -
    {{guard_pkg::CNT_W{1'b0}}, 1'b1};

  always_comb
  begin
    q_next = q_reg;
    q_next.expire = 1'b0;
    if (clear || !run)
    begin
      q_next.count = '0;
    end
    else if (lf_tick)
    begin
      if (q_reg.count == terminal[guard_pkg::CNT_W-1:0])
      begin
        q_next.count = '0;
        q_next.expire = 1'b1;
      end
      else
      begin
        q_next.count = q_reg.count + {{(guard_pkg::CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_reg <= CNT_RESET;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign expire = q_reg.expire;

endmodule
`default_nettype wire

// ===== core/watchdog_timer_unit.sv
// Watchdog block: AXI4-Lite registers, mode logic, sleep tracking.
// Assumes the core, sleep logic and tick source share aclk.
//
// How it works
// - An enabled watchdog requests system reset unless kicked before time-out.
// - The count advances on the low-frequency oscillator tick, 1 ms base.
// - Two-bit mode config 00 keeps the watchdog off regardless of anything.
// - Mode 11 keeps the watchdog active awake and asleep.
// - Mode 10 runs awake and stops during sleep.
// - Mode 01 follows the soft enable bit, unchanged by sleep.
// - Mode 01 with soft enable low holds the count cleared.
// - Five-bit period select spans 1 ms to 256 s, resets to 2 s.
// - Count clears on reset, kick, sleep entry, wake, osc failure, disable.
// - After the entry clear, an enabled watchdog keeps counting in sleep.
// - After waking, count stays zero until the startup timer finishes.
// - Time-out during sleep wakes the device instead of resetting it.
// - Time-out updates the expiry flag, plus the sleep flag if asleep or the reset cause if awake.
// - Oscillator divider changes never touch the watchdog count.
// - Sleep entry sets the expiry flag, clears the sleep flag, clears count.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [guard_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [guard_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] guard_mode_config,
  input wire logic lf_osc_tick,
  input wire logic kick_instruction,
  input wire logic in_sleep,
  input wire logic osc_fail,
  input wire logic ost_running,
  output logic guard_reset,
  output logic wake_request,
  output logic expiry_flag_n,
  output logic sleep_entered_flag_n,
  output logic irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic aw_have;
    logic [guard_pkg::ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [guard_pkg::PS_W-1:0] period_sel;
    logic soft_en;
    logic expiry_n;
    logic sleep_n;
    logic cause;
    logic [guard_pkg::IRQ_W-1:0] irq_stat;
    logic [guard_pkg::IRQ_W-1:0] irq_mask;
    guard_pkg::power_phase_e phase;
    logic guard_reset;
    logic wake_req;
  } unit_state_s;

  localparam unit_state_s UNIT_RESET = '{
    aw_have: 1'b0,
    aw_addr: '0,
    w_have: 1'b0,
    w_data: '0,
    w_strb: '0,
    bvalid: 1'b0,
    bresp: guard_pkg::RESP_OKAY,
    rvalid: 1'b0,
    rdata: '0,
    rresp: guard_pkg::RESP_OKAY,
    period_sel: guard_pkg::PS_RESET,
    soft_en: 1'b0,
    expiry_n: 1'b1,
    sleep_n: 1'b1,
    cause: 1'b0,
    irq_stat: '0,
    irq_mask: guard_pkg::IRQ_MASK_RESET,
    phase: guard_pkg::PH_AWAKE,
    guard_reset: 1'b0,
    wake_req: 1'b0
  };

  unit_state_s q_reg;
  unit_state_s q_next;
  logic active;
  logic clear_cnt;
  logic expire;
  logic entering;
  logic leaving;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  always_comb
  begin
    case (guard_mode_config)
      guard_pkg::MODE_ON: active = 1'b1;
      guard_pkg::MODE_AWAKE:
        active = (q_reg.phase != guard_pkg::PH_ASLEEP);
      guard_pkg::MODE_SOFT: active = q_reg.soft_en;
      default: active = 1'b0;
    endcase
  end

  assign entering = in_sleep && (q_reg.phase != guard_pkg::PH_ASLEEP);
  assign leaving = !in_sleep && (q_reg.phase == guard_pkg::PH_ASLEEP);

  assign clear_cnt = kick_instruction || entering || leaving ||
    osc_fail || !active || (q_reg.phase == guard_pkg::PH_HOLD);

  // The counter sees only the low-frequency tick, so the core clock
  // divider has no path into it.
  // independent time base
  guard_prescale_counter counter_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .lf_tick(lf_osc_tick),
    .run(active),
    .clear(clear_cnt),
    .period_sel(q_reg.period_sel),
    .expire(expire)
  );

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  assign s_axi_awready = !q_reg.aw_have && !q_reg.bvalid;
  assign s_axi_wready = !q_reg.w_have && !q_reg.bvalid;
  assign s_axi_arready = !q_reg.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [guard_pkg::ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic wlane;
    logic [guard_pkg::IRQ_W-1:0] irq_set;
    logic cause_set;
    waddr = q_reg.aw_have ? q_reg.aw_addr : s_axi_awaddr;
    wdata = q_reg.w_have ? q_reg.w_data : s_axi_wdata;
    wlane = q_reg.w_have ? q_reg.w_strb[0] : s_axi_wstrb[0];
    irq_set = '0;
    cause_set = 1'b0;
    q_next = q_reg;
    q_next.guard_reset = 1'b0;
    q_next.wake_req = 1'b0;

    // Write channel: address and data in either order.
    if (q_reg.bvalid && s_axi_bready)
    begin
      q_next.bvalid = 1'b0;
    end
    if (aw_hs)
    begin
      q_next.aw_have = 1'b1;
      q_next.aw_addr = s_axi_awaddr;
    end
    if (w_hs)
    begin
      q_next.w_have = 1'b1;
      q_next.w_data = s_axi_wdata;
      q_next.w_strb = s_axi_wstrb;
    end
    if ((q_reg.aw_have || aw_hs) && (q_reg.w_have || w_hs))
    begin
      q_next.aw_have = 1'b0;
      q_next.w_have = 1'b0;
      q_next.bvalid = 1'b1;
      q_next.bresp = guard_pkg::RESP_OKAY;
      case (waddr[guard_pkg::ADDR_W-1:2])
        guard_pkg::OFS_CONTROL[guard_pkg::ADDR_W-1:2]:
          if (wlane)
          begin
            q_next.soft_en = wdata[guard_pkg::CTRL_EN_BIT];
            q_next.period_sel =
              wdata[guard_pkg::CTRL_PS_LSB +: guard_pkg::PS_W];
          end
        guard_pkg::OFS_CPU_FLAGS[guard_pkg::ADDR_W-1:2]: ;
        guard_pkg::OFS_LIVE[guard_pkg::ADDR_W-1:2]: ;
        guard_pkg::OFS_POWER_CTRL[guard_pkg::ADDR_W-1:2]:
          if (wlane && wdata[guard_pkg::CAUSE_BIT])
          begin
            q_next.cause = 1'b0;
          end
        guard_pkg::OFS_IRQ_STATUS[guard_pkg::ADDR_W-1:2]:
          if (wlane)
          begin
            q_next.irq_stat = q_reg.irq_stat &
              ~wdata[guard_pkg::IRQ_W-1:0];
          end
        guard_pkg::OFS_IRQ_MASK[guard_pkg::ADDR_W-1:2]:
          if (wlane)
          begin
            q_next.irq_mask = wdata[guard_pkg::IRQ_W-1:0];
          end
        default: q_next.bresp = guard_pkg::RESP_SLVERR;
      endcase
    end

    // Read channel.
    if (q_reg.rvalid && s_axi_rready)
    begin
      q_next.rvalid = 1'b0;
    end
    if (ar_hs)
    begin
      q_next.rvalid = 1'b1;
      q_next.rdata = '0;
      q_next.rresp = guard_pkg::RESP_OKAY;
      case (s_axi_araddr[guard_pkg::ADDR_W-1:2])
        guard_pkg::OFS_CONTROL[guard_pkg::ADDR_W-1:2]:
        begin
          q_next.rdata[guard_pkg::CTRL_EN_BIT] = q_reg.soft_en;
          q_next.rdata[guard_pkg::CTRL_PS_LSB +: guard_pkg::PS_W] =
            q_reg.period_sel;
        end
        guard_pkg::OFS_CPU_FLAGS[guard_pkg::ADDR_W-1:2]:
        begin
          q_next.rdata[guard_pkg::FLAG_EXPIRY_BIT] = q_reg.expiry_n;
          q_next.rdata[guard_pkg::FLAG_SLEEP_BIT] = q_reg.sleep_n;
        end
        guard_pkg::OFS_POWER_CTRL[guard_pkg::ADDR_W-1:2]:
          q_next.rdata[guard_pkg::CAUSE_BIT] = q_reg.cause;
        guard_pkg::OFS_IRQ_STATUS[guard_pkg::ADDR_W-1:2]:
          q_next.rdata[guard_pkg::IRQ_W-1:0] = q_reg.irq_stat;
        guard_pkg::OFS_IRQ_MASK[guard_pkg::ADDR_W-1:2]:
          q_next.rdata[guard_pkg::IRQ_W-1:0] = q_reg.irq_mask;
        guard_pkg::OFS_LIVE[guard_pkg::ADDR_W-1:2]:
          q_next.rdata[2:0] = {active, q_reg.phase[2], |q_reg.phase[2:1]};
        default: q_next.rresp = guard_pkg::RESP_SLVERR;
      endcase
    end

    // ****************************************************************
    // Power phase
    // ****************************************************************
    case (q_reg.phase)
      guard_pkg::PH_AWAKE:
        if (in_sleep)
        begin
          q_next.phase = guard_pkg::PH_ASLEEP;
        end
      guard_pkg::PH_ASLEEP:
        if (!in_sleep)
        begin
          q_next.phase = ost_running ?
            guard_pkg::PH_HOLD : guard_pkg::PH_AWAKE;
        end
      guard_pkg::PH_HOLD:
        if (in_sleep)
        begin
          q_next.phase = guard_pkg::PH_ASLEEP;
        end
        else if (!ost_running)
        begin
          q_next.phase = guard_pkg::PH_AWAKE;
        end
      default: q_next.phase = guard_pkg::PH_AWAKE;
    endcase

    // ****************************************************************
    // Flags
    // ****************************************************************
    if (kick_instruction)
    begin
      q_next.expiry_n = 1'b1;
      q_next.sleep_n = 1'b1;
    end
    if (entering)
    begin
      q_next.expiry_n = 1'b1;
      q_next.sleep_n = 1'b0;
    end
    // A time-out is reported one cycle after the terminal tick, so it
    // is judged by the phase held at that moment.
    if (expire)
    begin
      q_next.expiry_n = 1'b0;
      if (q_reg.phase == guard_pkg::PH_ASLEEP)
      begin
        q_next.wake_req = 1'b1;
        q_next.sleep_n = 1'b0;
        irq_set[guard_pkg::IRQ_WAKE_BIT] = 1'b1;
      end
      else
      begin
        q_next.guard_reset = 1'b1;
        cause_set = 1'b1;
        irq_set[guard_pkg::IRQ_RESET_BIT] = 1'b1;
      end
    end
    // Set wins over a clear written in the same cycle.
    q_next.irq_stat = q_next.irq_stat | irq_set;
    q_next.cause = q_next.cause | cause_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_reg <= UNIT_RESET;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_bvalid = q_reg.bvalid;
  assign s_axi_bresp = q_reg.bresp;
  assign s_axi_rvalid = q_reg.rvalid;
  assign s_axi_rdata = q_reg.rdata;
  assign s_axi_rresp = q_reg.rresp;
  assign guard_reset = q_reg.guard_reset;
  assign wake_request = q_reg.wake_req;
  assign expiry_flag_n = q_reg.expiry_n;
  assign sleep_entered_flag_n = q_reg.sleep_n;
  assign irq = |(q_reg.irq_stat & q_reg.irq_mask);

endmodule
`default_nettype wire

// ===== shared/guard_pkg.sv
// Constants, field positions and types shared by the watchdog block.
// Assumes a 20 MHz bus clock and a low-frequency tick input.
`default_nettype none
package guard_pkg;

  // ****************************************************************
  // Time base
  // ****************************************************************
  localparam int LF_OSC_HZ = 31000;
  localparam int BASE_TICK_MS = 1;
  localparam int CNT_W = 23;
  localparam logic [CNT_W:0] BASE_PRESCALE = 24'h000020;
  localparam int PS_W = 5;
  localparam logic [PS_W-1:0] PS_MAX = 5'h12;
  localparam logic [PS_W-1:0] PS_RESET = 5'h0B;

  // ****************************************************************
  // Modes
  // ****************************************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SOFT = 2'h1;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_ON = 2'h3;

  typedef enum logic [2:0] {
    PH_AWAKE = 3'h1,
    PH_ASLEEP = 3'h2,
    PH_HOLD = 3'h4
  } power_phase_e;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CPU_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_POWER_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LIVE = 8'h14;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PS_LSB = 1;
  localparam int FLAG_SLEEP_BIT = 3;
  localparam int FLAG_EXPIRY_BIT = 4;
  localparam int CAUSE_BIT = 0;
  localparam int IRQ_W = 2;
  localparam int IRQ_RESET_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// ===== tb/guard_core_model.sv
// Model of the core side: oscillator tick, sleep logic, startup timer.
// Assumes the bench asks for sleep by holding sleep_cmd high.
`timescale 1ns/1ps
`default_nettype none
module guard_core_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_cmd,
  input wire logic wake_request,
  output logic lf_osc_tick,
  output logic in_sleep,
  output logic ost_running
);
  // ********
  // Behaviour
  // ********
  logic [3:0] div;
  logic [2:0] oscillator_startup_timer;
  logic woke;
  logic nxt;
  assign nxt = sleep_cmd && !woke && !wake_request;
  assign ost_running = oscillator_startup_timer != 3'h0;
  always_ff @(posedge aclk)
  begin
    // The divider starts from reset so the tick is never unknown.
    if (!aresetn)
    begin
      div <= 4'h0;
      lf_osc_tick <= 1'b0;
      in_sleep <= 1'b0;
      oscillator_startup_timer <= 3'h0;
      woke <= 1'b0;
    end
    else
    begin
      div <= (div == 4'(TICK_DIV - 1)) ? 4'h0 : div + 4'h1;
      lf_osc_tick <= (div == 4'h0);
      if (wake_request)
        woke <= 1'b1;
      else if (!sleep_cmd)
        woke <= 1'b0;
      in_sleep <= nxt;
      if (in_sleep && !nxt)
        oscillator_startup_timer <= 3'h5;
      else if (oscillator_startup_timer != 3'h0)
        oscillator_startup_timer <= oscillator_startup_timer - 3'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/watchdog_timer_unit_sva.sv
// Checker of the watchdog block, watching its ports only.
// Assumes one clock domain; it is bound into the block.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_unit_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] guard_mode_config,
  input wire logic lf_osc_tick,
  input wire logic kick_instruction,
  input wire logic in_sleep,
  input wire logic osc_fail,
  input wire logic ost_running,
  input wire logic guard_reset,
  input wire logic wake_request,
  input wire logic expiry_flag_n,
  input wire logic sleep_entered_flag_n
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_enter;
    !in_sleep ##1 in_sleep;
  endsequence
  sequence s_quiet;
    !guard_reset && !wake_request;
  endsequence
  a_rst_pulse: assert property (
    guard_reset |=> !guard_reset)
    else $error("reset request held too long");
  a_tick_cause: assert property (
    (guard_reset || wake_request) |-> $past(lf_osc_tick, 2))
    else $error("time-out not two edges after a tick");
  a_off_quiet: assert property (
    (guard_mode_config == guard_pkg::MODE_OFF)[*3] |-> s_quiet)
    else $error("time-out while mode is off");
  a_awake_only: assert property (
    (guard_mode_config == guard_pkg::MODE_AWAKE && in_sleep)[*3]
    |-> s_quiet)
    else $error("time-out asleep in awake-only mode");
  a_kick_quiet: assert property (
    kick_instruction |-> ##2 s_quiet [*4])
    else $error("time-out soon after a kick");
  a_fail_quiet: assert property (
    osc_fail[*3] |-> s_quiet)
    else $error("time-out during oscillator failure");
  a_kick_flags: assert property (
    (kick_instruction ##1 s_quiet) |-> expiry_flag_n && sleep_entered_flag_n)
    else $error("kick did not set both flags");
  a_sleep_flags: assert property (
    s_enter |=> expiry_flag_n && !sleep_entered_flag_n)
    else $error("sleep entry flags wrong");
  a_sleep_no_rst: assert property (
    in_sleep[*3] |-> !guard_reset)
    else $error("reset requested during sleep");
  a_wake_asleep: assert property (
    wake_request |-> $past(in_sleep, 2) && !guard_reset)
    else $error("wake request while awake");
  a_ost_quiet: assert property (
    ost_running[*3] |-> s_quiet)
    else $error("time-out while startup timer runs");
endmodule
bind watchdog_timer_unit watchdog_timer_unit_sva chk_i (.aclk, .aresetn,
  .guard_mode_config, .lf_osc_tick, .kick_instruction, .in_sleep, .osc_fail,
  .ost_running, .guard_reset, .wake_request, .expiry_flag_n,
  .sleep_entered_flag_n);
`default_nettype wire

// ===== tb/watchdog_timer_unit_tb.sv
// Bench of the watchdog block: register tasks and mode scenarios.
// Assumes the core model ticks every four clocks.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_unit_tb;
  // ********
  // Signals
  // ********
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, kick_instruction;
  logic in_sleep, osc_fail, ost_running, guard_reset, wake_request;
  logic expiry_flag_n, sleep_entered_flag_n, irq, lf_osc_tick, sleep_cmd;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, guard_mode_config, rs;
  int mismatches = 0, compares = 0, n_rst = 0, n_wake = 0, ticks = 0;
  int t0 = 0, span = 0, c, w, i;
  logic [1:0] mt [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
  int en [6] = '{1, 0, 1, 0, 0, 0};
  int fl [6] = '{0, 0, 0, 0, 1, 0};
  int ex [6] = '{0, 0, 1, 1, 0, 1};
  watchdog_timer_unit dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .guard_mode_config,
    .lf_osc_tick, .kick_instruction, .in_sleep, .osc_fail, .ost_running,
    .guard_reset, .wake_request, .expiry_flag_n, .sleep_entered_flag_n,
    .irq);
  guard_core_model #(.TICK_DIV(4)) core (.aclk, .aresetn, .sleep_cmd,
    .wake_request, .lf_osc_tick, .in_sleep, .ost_running);
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    if (lf_osc_tick === 1'b1) ticks <= ticks + 1;
    if (kick_instruction) t0 <= ticks;
    if (guard_reset === 1'b1) n_rst <= n_rst + 1;
    if (guard_reset === 1'b1) span <= ticks - t0;
    if (wake_request === 1'b1) n_wake <= n_wake + 1;
  end
  // ********
  // Tasks
  // ********
  task automatic close_out;
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
    input string nm);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_up(input int n);
    if (n >= 40)
    begin
      mismatches++;
      close_out();
    end
  endtask
  // A hang in the handshake ends the run through give_up.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    give_up(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    give_up(n);
  endtask
  // The kick lands just after a tick so the two never coincide.
  task automatic do_kick;
    int n;
    for (n = 0; n < 8; n++)
    begin
      @(posedge aclk);
      if (lf_osc_tick) break;
    end
    if (n >= 8) give_up(40);
    kick_instruction <= 1'b1;
    @(posedge aclk);
    kick_instruction <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic wait_ticks(input int k);
    int n;
    int s;
    s = ticks;
    for (n = 0; n < k * 8 && ticks < s + k; n++) @(posedge aclk);
    if (ticks < s + k) give_up(40);
  endtask
  // ********
  // Sequence
  // ********
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, kick_instruction, osc_fail} = 4'h0;
    {sleep_cmd, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    guard_mode_config = 2'h3;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00);
    chk(rv, {26'h0, 5'h0B, 1'b0}, "control");
    rd(8'h04);
    chk(rv, 32'h18, "cpu flags");
    rd(8'h14);
    chk(rv, 32'h4, "live awake");
    rd(8'h20);
    chk(rs, guard_pkg::RESP_SLVERR, "unmapped read");
    chk(rv, 32'h0, "unmapped data");
    wr(8'h20, 32'h1);
    chk(rs, guard_pkg::RESP_SLVERR, "unmapped write");
    for (i = 0; i < 6; i++)
    begin
      guard_mode_config <= mt[i];
      osc_fail <= fl[i][0];
      wr(8'h00, en[i]);
      do_kick();
      c = n_rst;
      wait_ticks(40);
      chk(n_rst - c, ex[i], "reset count");
    end
    guard_mode_config <= guard_pkg::MODE_OFF;
    chk(span, 32, "ticks to expiry");
    chk(expiry_flag_n, 1'b0, "expiry flag");
    rd(8'h08);
    chk(rv, 32'h1, "reset cause");
    rd(8'h0C);
    chk(rv, 32'h1, "irq status");
    chk(irq, 1'b0, "irq masked");
    wr(8'h10, 32'h1);
    chk(irq, 1'b1, "irq unmasked");
    wr(8'h0C, 32'h1);
    wr(8'h08, 32'h1);
    chk(irq, 1'b0, "irq cleared");
    rd(8'h08);
    chk(rv, 32'h0, "cause cleared");
    do_kick();
    chk(expiry_flag_n, 1'b1, "flag after kick");
    guard_mode_config <= guard_pkg::MODE_ON;
    do_kick();
    sleep_cmd <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(expiry_flag_n, 1'b1, "expiry on entry");
    chk(sleep_entered_flag_n, 1'b0, "sleep flag");
    c = n_rst;
    w = n_wake;
    wait_ticks(40);
    chk(n_wake - w, 1, "wake count");
    chk(n_rst - c, 0, "reset in sleep");
    chk(expiry_flag_n, 1'b0, "expiry in sleep");
    rd(8'h0C);
    chk(rv, 32'h2, "wake status");
    sleep_cmd <= 1'b0;
    guard_mode_config <= guard_pkg::MODE_AWAKE;
    do_kick();
    sleep_cmd <= 1'b1;
    c = n_rst;
    w = n_wake;
    wait_ticks(40);
    chk(n_wake - w + n_rst - c, 0, "awake-only sleep");
    rd(8'h14);
    chk(rv, 32'h1, "live asleep");
    close_out();
  end
endmodule
`default_nettype wire
